// *** rtl/pshp_map.vh ***
`ifndef PSHP_MAP_VH
`define PSHP_MAP_VH

// ****************************************************************
// Mode numbers
// ****************************************************************
`define PSHP_MODE1      4'h1
`define PSHP_MODE2      4'h2
`define PSHP_MODE3      4'h3
`define PSHP_MODE4      4'h4
`define PSHP_MODE5      4'h5
`define PSHP_MODE6      4'h6
`define PSHP_MODE9      4'h9
`define PSHP_MODE10     4'hA

// ****************************************************************
// Memory map (byte addresses)
// ****************************************************************
`define PSHP_REG_TOP    6'h3F
`define PSHP_REG_PLAIN  2'h0
`define PSHP_REG_WIN    2'h1
`define PSHP_REG_SET    2'h2
`define PSHP_REG_CLR    2'h3
`define PSHP_WIN_GP     15'h7E80
`define PSHP_WIN_RX     15'h7E82
`define PSHP_WIN_UD     15'h7E84

// ****************************************************************
// Memory commands and window codes
// ****************************************************************
`define PSHP_CMD_WRITE  2'h0
`define PSHP_CMD_SET    2'h1
`define PSHP_CMD_CLR    2'h2
`define PSHP_WSEL_NONE  2'h0
`define PSHP_WSEL_GP    2'h1
`define PSHP_WSEL_RX    2'h2
`define PSHP_WSEL_UD    2'h3

// ****************************************************************
// Timing
// ****************************************************************
`define PSHP_STRAP_WAIT 3'h5
`define PSHP_RESET_LAT  15'h0000

`endif

// *** rtl/pshp_port.v ***
`timescale 1ns/1ps
`include "pshp_map.vh"
module pshp_port (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        irq_serial_select_pin,
    input  wire [4:0]  mode_strap_pins,
    input  wire        cs,
    input  wire        address_latch_strobe,
    input  wire        rd_rnw_pin,
    input  wire        wr_en_pin,
    input  wire        low_lane_write_strobe,
    input  wire        high_lane_write_strobe,
    input  wire [14:0] addr_pin,
    input  wire [15:0] ad_in,
    output wire [15:0] ad_out,
    output wire [15:0] ad_oe_n,
    output wire        cs_pulldown_en,
    output wire        parallel_slave_port_en,
    output wire        serial_port_en,
    output wire [3:0]  port_mode,
    output wire [14:0] mem_addr,
    output wire [1:0]  mem_be,
    output wire [1:0]  mem_cmd,
    output wire [15:0] mem_wdata,
    output wire        mem_wr,
    output wire        mem_rd,
    input  wire [15:0] mem_rdata,
    input  wire [2:0]  win_ptr_load,
    input  wire [14:0] win_ptr_load_val,
    output wire [14:0] gp_win_ptr,
    output wire [14:0] rx_win_ptr,
    output wire [14:0] ud_win_ptr
);

    // ************************************************************
    // Helper functions
    // ************************************************************
    // Strap code to mode number
    function [3:0] pshp_mode;
        input [2:0] s;
        begin
            case (s)
                3'h0:    pshp_mode = `PSHP_MODE1;
                3'h4:    pshp_mode = `PSHP_MODE2;
                3'h1:    pshp_mode = `PSHP_MODE3;
                3'h5:    pshp_mode = `PSHP_MODE4;
                3'h2:    pshp_mode = `PSHP_MODE5;
                3'h6:    pshp_mode = `PSHP_MODE6;
                3'h3:    pshp_mode = `PSHP_MODE9;
                default: pshp_mode = `PSHP_MODE10;
            endcase
        end
    endfunction

    // Which data window a byte address hits, if any
    function [1:0] pshp_wsel;
        input [14:0] a;
        input        w16;
        reg   [14:0] m;
        begin
            m = w16 ? {a[14:1], 1'b0} : a;
            if (m == `PSHP_WIN_GP)
                pshp_wsel = `PSHP_WSEL_GP;
            else if (m == `PSHP_WIN_RX)
                pshp_wsel = `PSHP_WSEL_RX;
            else if (m == `PSHP_WIN_UD)
                pshp_wsel = `PSHP_WSEL_UD;
            else
                pshp_wsel = `PSHP_WSEL_NONE;
        end
    endfunction

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    // Three stages; a bit moves only when stages two and three agree
    wire [40:0] pin_vec = {irq_serial_select_pin, mode_strap_pins[4:2], cs,
                           address_latch_strobe, rd_rnw_pin, wr_en_pin,
                           low_lane_write_strobe, high_lane_write_strobe,
                           addr_pin, ad_in};
    reg  [40:0] in_s1_r;
    reg  [40:0] in_s2_r;
    reg  [40:0] in_s3_r;
    reg  [40:0] filt_r;
    always @(posedge ref_clk) begin
        in_s1_r <= pin_vec;
        in_s2_r <= in_s1_r;
        in_s3_r <= in_s2_r;
        filt_r  <= (in_s2_r & in_s3_r) | (filt_r & (in_s2_r | in_s3_r));
    end

    wire        f_sel  = filt_r[40];
    wire [2:0]  f_cfg  = filt_r[39:37];
    wire        f_cs   = filt_r[36];
    wire        f_al   = filt_r[35];
    wire        f_rd   = filt_r[34];
    wire        f_wr   = filt_r[33];
    wire        f_lo   = filt_r[32];
    wire        f_hi   = filt_r[31];
    wire [14:0] f_addr = filt_r[30:16];
    wire [15:0] f_ad   = filt_r[15:0];

    // ************************************************************
    // Strap capture
    // ************************************************************
    // Straps are static, so one capture after the chain settles is enough
    reg  [2:0] strap_cnt_r;
    reg        strap_ok_r;
    reg        port_en_r;
    reg  [3:0] mode_r;
    always @(posedge ref_clk) begin
        if (rst) begin
            strap_cnt_r <= 3'h0;
            strap_ok_r  <= 1'b0;
            port_en_r   <= 1'b0;
            mode_r      <= `PSHP_MODE1;
        end else if (!strap_ok_r) begin
            if (strap_cnt_r == `PSHP_STRAP_WAIT) begin
                strap_ok_r <= 1'b1;
                port_en_r  <= ~f_sel;
                mode_r     <= pshp_mode(f_cfg);
            end else begin
                strap_cnt_r <= strap_cnt_r + 3'h1;
            end
        end
    end

    // Mode flavour bits
    wire wide  = (mode_r == `PSHP_MODE3) | (mode_r == `PSHP_MODE4) |
                 (mode_r == `PSHP_MODE9) | (mode_r == `PSHP_MODE10);
    wire muxed = (mode_r == `PSHP_MODE5) | (mode_r == `PSHP_MODE6) |
                 (mode_r == `PSHP_MODE9) | (mode_r == `PSHP_MODE10);
    wire enstl = ~mode_r[0];

    // ************************************************************
    // Strobe decode
    // ************************************************************
    // Floating select arrives low through the pad pull-down
    wire live  = port_en_r & f_cs;
    wire lanes = f_lo | f_hi;
    wire rd_raw = enstl ? ((wide ? lanes : f_wr) & f_rd) : f_rd;
    wire wr_raw = enstl ? ((wide ? lanes : f_wr) & ~f_rd) : (wide ? lanes : f_wr);
    wire rd_act = live & rd_raw;
    wire wr_act = live & wr_raw;
    wire [1:0] lane_be = wide ? {f_hi, f_lo} : 2'h1;

    // ************************************************************
    // Address latch
    // ************************************************************
    // Follows the pins while the strobe is high, freezes on its fall
    reg [14:0] lat_r;
    always @(posedge ref_clk) begin
        if (rst)
            lat_r <= `PSHP_RESET_LAT;
        else if (muxed & live & f_al)
            lat_r <= wide ? {1'b0, f_ad[13:0]} : f_ad[14:0];
    end

    // Byte address of the current access; latch never advanced
    wire [14:0] src  = muxed ? lat_r : f_addr;
    wire [14:0] cur  = wide ? {src[13:0], 1'b0} : src;

    // ************************************************************
    // Access engine
    // ************************************************************
    reg         rd_prev_r;
    reg         wr_prev_r;
    reg         rd_pend_r;
    reg         rd_byte_r;
    reg  [14:0] wa_r;
    reg  [1:0]  be_acc_r;
    reg  [15:0] wd_r;
    reg  [15:0] dout_r;
    reg  [14:0] maddr_r;
    reg  [1:0]  mbe_r;
    reg  [1:0]  mcmd_r;
    reg  [15:0] mwd_r;
    reg         mwr_r;
    reg         mrd_r;
    reg  [14:0] ptr_r [0:2];

    wire [1:0]  rsel = pshp_wsel(cur, wide);
    wire [1:0]  wsel = pshp_wsel(wa_r, wide);
    wire        wreg = wa_r[14:9] == `PSHP_REG_TOP;
    wire [1:0]  wkind = wa_r[8:7];
    wire        rd_go = rd_act & ~rd_prev_r;
    wire        wr_go = wr_prev_r & ~wr_raw & f_cs & port_en_r;
    wire [1:0]  rinc = (rd_go && rsel != `PSHP_WSEL_NONE) ? rsel : `PSHP_WSEL_NONE;
    wire [1:0]  winc = (wr_go && wsel != `PSHP_WSEL_NONE) ? wsel : `PSHP_WSEL_NONE;

    // Bus side: reads launch on strobe rise, writes commit on strobe fall
    always @(posedge ref_clk) begin
        if (rst) begin
            rd_prev_r <= 1'b0;
            wr_prev_r <= 1'b0;
            rd_pend_r <= 1'b0;
            rd_byte_r <= 1'b0;
            wa_r      <= 15'h0000;
            be_acc_r  <= 2'h0;
            wd_r      <= 16'h0000;
            dout_r    <= 16'h0000;
            maddr_r   <= 15'h0000;
            mbe_r     <= 2'h0;
            mcmd_r    <= `PSHP_CMD_WRITE;
            mwd_r     <= 16'h0000;
            mwr_r     <= 1'b0;
            mrd_r     <= 1'b0;
        end else begin
            rd_prev_r <= rd_act;
            wr_prev_r <= wr_act;
            rd_pend_r <= mrd_r;
            mwr_r     <= 1'b0;
            mrd_r     <= 1'b0;
            // Lanes gathered across the whole pulse, write data taken from its last cycle
            if (wr_act & ~wr_prev_r) begin
                wa_r     <= cur;
                be_acc_r <= lane_be;
                wd_r     <= f_ad;
            end else if (wr_act) begin
                be_acc_r <= be_acc_r | lane_be;
                wd_r     <= f_ad;
            end
            if (rd_go) begin
                mrd_r     <= 1'b1;
                mcmd_r    <= `PSHP_CMD_WRITE;
                rd_byte_r <= ~wide | (rsel != `PSHP_WSEL_NONE);
                if (rsel != `PSHP_WSEL_NONE) begin
                    maddr_r <= ptr_r[rsel - 2'h1];
                    mbe_r   <= 2'h1;
                end else begin
                    maddr_r <= cur;
                    mbe_r   <= wide ? 2'h3 : 2'h1;
                end
            end else if (wr_go) begin
                mwr_r <= 1'b1;
                if (wsel != `PSHP_WSEL_NONE) begin
                    // Window writes move one byte whatever the width
                    maddr_r <= ptr_r[wsel - 2'h1];
                    mbe_r   <= 2'h1;
                    mcmd_r  <= `PSHP_CMD_WRITE;
                    mwd_r   <= {8'h00, (wide & ~be_acc_r[0]) ? wd_r[15:8] : wd_r[7:0]};
                end else begin
                    mbe_r <= be_acc_r;
                    mwd_r <= wd_r;
                    if (wreg & wkind[1]) begin
                        // Companion alias maps onto its base register
                        maddr_r <= {`PSHP_REG_TOP, 2'h0, wa_r[6:0]};
                        mcmd_r  <= wkind[0] ? `PSHP_CMD_CLR : `PSHP_CMD_SET;
                    end else begin
                        maddr_r <= wa_r;
                        mcmd_r  <= `PSHP_CMD_WRITE;
                    end
                end
            end
            // Read data one cycle after the memory request
            if (rd_pend_r)
                dout_r <= rd_byte_r ? {8'h00, mem_rdata[7:0]} : mem_rdata;
        end
    end

    // ************************************************************
    // Window pointers
    // ************************************************************
    // A load from the core wins over an access in the same cycle
    integer i;
    always @(posedge ref_clk) begin
        for (i = 0; i < 3; i = i + 1) begin
            if (rst)
                ptr_r[i] <= 15'h0000;
            else if (win_ptr_load[i])
                ptr_r[i] <= win_ptr_load_val;
            else if (rinc == i + 1 || winc == i + 1)
                ptr_r[i] <= ptr_r[i] + 15'h0001;
        end
    end

    // ************************************************************
    // Pin drive
    // ************************************************************
    // Raw select also gates the drivers so release is not delayed
    wire drive = rd_prev_r & rd_act & cs;
    assign ad_oe_n[7:0]  = {8{~drive}};
    assign ad_oe_n[15:8] = {8{~(drive & wide)}};
    assign ad_out        = dout_r;

    assign cs_pulldown_en         = port_en_r;
    assign parallel_slave_port_en = port_en_r;
    assign serial_port_en         = strap_ok_r & ~port_en_r;
    assign port_mode              = mode_r;
    assign mem_addr               = maddr_r;
    assign mem_be                 = mbe_r;
    assign mem_cmd                = mcmd_r;
    assign mem_wdata              = mwd_r;
    assign mem_wr                 = mwr_r;
    assign mem_rd                 = mrd_r;
    assign gp_win_ptr             = ptr_r[0];
    assign rx_win_ptr             = ptr_r[1];
    assign ud_win_ptr             = ptr_r[2];

endmodule

// *** testbench/pshp_port_properties.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Port checker
// ****************************************************************
module pshp_port_properties (
    input wire        ref_clk,
    input wire        rst,
    input wire        cs,
    input wire [15:0] ad_oe_n,
    input wire [15:0] ad_out,
    input wire        parallel_slave_port_en,
    input wire        serial_port_en,
    input wire [3:0]  port_mode,
    input wire [14:0] mem_addr,
    input wire [1:0]  mem_be,
    input wire        mem_wr,
    input wire        mem_rd,
    input wire [15:0] mem_rdata,
    input wire [2:0]  win_ptr_load,
    input wire [14:0] gp_win_ptr,
    input wire [14:0] rx_win_ptr,
    input wire [14:0] ud_win_ptr
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Both interfaces must never be live together
    property p_excl; parallel_slave_port_en |-> !serial_port_en; endproperty
    property p_off_hiz; !parallel_slave_port_en |-> &ad_oe_n; endproperty
    property p_cs_hiz; !cs |-> &ad_oe_n; endproperty
    // Six low samples outlast the input filter, so nothing may start
    property p_cs_ignore; !cs [*6] |-> !mem_wr && !mem_rd; endproperty
    property p_wr_once; mem_wr |=> !mem_wr; endproperty
    property p_mode_legal;
        port_mode inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'hA};
    endproperty
    property p_narrow_hiz;
        port_mode inside {4'h1, 4'h2, 4'h5, 4'h6} |-> &ad_oe_n[15:8];
    endproperty
    // A GP pointer step beside a write marks a window write through that pointer
    property p_win_byte;
        mem_wr && !$past(win_ptr_load[0]) && gp_win_ptr != $past(gp_win_ptr)
            |-> mem_be == 2'h1 && mem_addr == $past(gp_win_ptr);
    endproperty
    // Window accesses step a pointer and may hit odd bytes, so leave them out
    property p_word_even;
        (mem_wr || mem_rd) && port_mode inside {4'h3, 4'h4, 4'h9, 4'hA}
            && mem_addr < 15'h7E00 && $stable(gp_win_ptr) && $stable(rx_win_ptr)
            && $stable(ud_win_ptr) |-> !mem_addr[0];
    endproperty
    property p_rd_data;
        mem_rd && port_mode == 4'h3 && mem_addr < 15'h7E00 |-> ##2 ad_out == $past(mem_rdata);
    endproperty
    a_excl: assert property (p_excl) else $error("both ports enabled");
    a_off_hiz: assert property (p_off_hiz) else $error("bus driven while off");
    a_cs_hiz: assert property (p_cs_hiz) else $error("bus driven while deselected");
    a_cs_ignore: assert property (p_cs_ignore) else $error("access while deselected");
    a_wr_once: assert property (p_wr_once) else $error("write pulse too long");
    a_mode_legal: assert property (p_mode_legal) else $error("illegal mode");
    a_narrow_hiz: assert property (p_narrow_hiz) else $error("upper lane driven");
    a_win_byte: assert property (p_win_byte) else $error("window write not a byte");
    a_word_even: assert property (p_word_even) else $error("odd word address");
    a_rd_data: assert property (p_rd_data) else $error("read data not returned");
    c_wr_low: cover property (mem_wr && mem_be == 2'h1);
    c_wr_word: cover property (mem_wr && mem_be == 2'h3);
    c_rd: cover property (mem_rd && port_mode == 4'h5);
endmodule

bind pshp_port pshp_port_properties chk (.ref_clk(ref_clk), .rst(rst), .cs(cs),
    .ad_oe_n(ad_oe_n), .ad_out(ad_out), .parallel_slave_port_en(parallel_slave_port_en),
    .serial_port_en(serial_port_en), .port_mode(port_mode), .mem_addr(mem_addr),
    .mem_be(mem_be), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
    .win_ptr_load(win_ptr_load), .gp_win_ptr(gp_win_ptr), .rx_win_ptr(rx_win_ptr),
    .ud_win_ptr(ud_win_ptr));

// *** testbench/pshp_host.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Host side of the pin bus
// ****************************************************************
module pshp_host (
    input  wire        ref_clk,
    output reg         cs,
    output reg  [4:0]  stb,
    output reg  [14:0] addr,
    output reg  [15:0] ad
);
    initial begin
        cs = 1'b1;
        stb = 5'h00;
        addr = 15'h0000;
        ad = 16'h0000;
    end
    // Levels held over the whole cycle, pulse bits raised 8 cycles
    task access(input [14:0] a, input [15:0] d, input [4:0] lvl, input [4:0] pls,
                input c);
        begin
            @(posedge ref_clk); #1;
            cs = c;
            addr = a;
            ad = d;
            stb = lvl;
            repeat (3) @(posedge ref_clk); #1;
            stb = lvl | pls;
            repeat (8) @(posedge ref_clk); #1;
            stb = lvl;
            repeat (5) @(posedge ref_clk); #1;
            stb = 5'h00;
            // Released lines show junk, never the old value
            ad = ~d;
            addr = ~a;
            repeat (4) @(posedge ref_clk);
        end
    endtask
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    localparam [31:0] MTAB = 32'hA6429531;
    localparam [4:0] S_AL = 5'h01, S_RD = 5'h02, S_WR = 5'h04, S_LL = 5'h08, S_HL = 5'h10;
    reg         ref_clk = 1'b0, rst = 1'b1, irq_sel = 1'b0, w16 = 1'b0;
    reg  [4:0]  straps = 5'h00;
    reg  [2:0]  win_ptr_load = 3'h0;
    reg  [14:0] win_ptr_load_val = 15'h0000;
    reg  [15:0] mem_rdata = 16'h0000, exp_rd = 16'h0000, last_wd, rnd;
    reg  [14:0] last_wa, last_ra, a, p0;
    reg  [1:0]  last_be, last_cmd, rd_d = 2'h0;
    reg  [7:0]  mem [0:32767];
    integer     fails = 0, checks = 0, wr_cnt = 0, rd_cnt = 0, cyc = 0, i, k, n;
    wire        cs;
    wire [4:0]  stb;
    wire [14:0] addr_pin, mem_addr, gp_win_ptr, rx_win_ptr, ud_win_ptr;
    wire [15:0] host_ad, ad_out, ad_oe_n, mem_wdata;
    wire [3:0]  port_mode;
    wire [1:0]  mem_be, mem_cmd;
    wire        pd_en, psp_en, ser_en, mem_wr, mem_rd;
    wire [15:0] ad_in = (ad_oe_n & host_ad) | (~ad_oe_n & ad_out);
    always #20 ref_clk = ~ref_clk;
    pshp_host host (.ref_clk(ref_clk), .cs(cs), .stb(stb), .addr(addr_pin), .ad(host_ad));
    pshp_port dut (.ref_clk(ref_clk), .rst(rst), .irq_serial_select_pin(irq_sel),
        .mode_strap_pins(straps), .cs(cs), .address_latch_strobe(stb[0]),
        .rd_rnw_pin(stb[1]), .wr_en_pin(stb[2]), .low_lane_write_strobe(stb[3]),
        .high_lane_write_strobe(stb[4]), .addr_pin(addr_pin), .ad_in(ad_in),
        .ad_out(ad_out), .ad_oe_n(ad_oe_n), .cs_pulldown_en(pd_en),
        .parallel_slave_port_en(psp_en), .serial_port_en(ser_en), .port_mode(port_mode),
        .mem_addr(mem_addr), .mem_be(mem_be), .mem_cmd(mem_cmd), .mem_wdata(mem_wdata),
        .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
        .win_ptr_load(win_ptr_load), .win_ptr_load_val(win_ptr_load_val),
        .gp_win_ptr(gp_win_ptr), .rx_win_ptr(rx_win_ptr), .ud_win_ptr(ud_win_ptr));
    task check(input string nm, input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("unexpected %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d fails %0d", checks, fails);
            if (fails == 0 && checks > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    task do_reset(input [2:0] code, input sel);
        begin
            #1 straps = {code, 2'b00};
            irq_sel = sel;
            w16 = code[0];
            repeat (4) @(posedge ref_clk); #1 rst = 1'b1;
            repeat (2) @(posedge ref_clk); #1 rst = 1'b0;
            repeat (10) @(posedge ref_clk);
        end
    endtask
    function [14:0] ptr_of(input integer w);
        ptr_of = (w == 0) ? gp_win_ptr : (w == 1) ? rx_win_ptr : ud_win_ptr;
    endfunction
    // ****************************************************************
    // Memory core model and result monitor
    // ****************************************************************
    always @(posedge ref_clk) begin
        rd_d <= {rd_d[0], mem_rd};
        mem_rdata <= ~mem_rdata;
        cyc <= cyc + 1;
        if (mem_rd) begin
            mem_rdata <= {mem[mem_addr + 15'h1], mem[mem_addr]};
            exp_rd <= w16 ? {mem[mem_addr + 15'h1], mem[mem_addr]} : {8'h00, mem[mem_addr]};
            last_ra <= mem_addr;
            rd_cnt <= rd_cnt + 1;
        end
        if (mem_wr) begin
            for (k = 0; k < 2; k = k + 1)
                if (mem_be[k]) begin
                    n = mem_addr + k;
                    if (mem_cmd == 2'h1) mem[n] = mem[n] | mem_wdata[8*k +: 8];
                    else if (mem_cmd == 2'h2) mem[n] = mem[n] & ~mem_wdata[8*k +: 8];
                    else mem[n] = mem_wdata[8*k +: 8];
                end
            {last_wa, last_be, last_cmd, last_wd} <= {mem_addr, mem_be, mem_cmd, mem_wdata};
            wr_cnt <= wr_cnt + 1;
        end
        if (cyc == 6000) begin
            fails = fails + 1;
            complete_run;
        end
    end
    // Read data settles two cycles after the core read
    always @(negedge ref_clk) if (rd_d[1]) check("ad_out", ad_out, exp_rd);
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        rnd = $urandom(32'hd419af05);
        for (i = 0; i < 32768; i = i + 1) mem[i] = i[7:0] ^ 8'h5A;
        repeat (2) @(posedge ref_clk); #1 rst = 1'b0;
        repeat (10) @(posedge ref_clk);
        check("mode", port_mode, 4'h1);
        check("enables", {pd_en, psp_en, ser_en}, 3'h6);
        for (i = 0; i < 3; i = i + 1) begin
            a = $urandom_range(0, 32255);
            rnd = $urandom;
            host.access(a, rnd, 5'h00, S_WR, 1'b1);
            check("waddr", last_wa, a);
            check("wbyte", {last_be, last_wd[7:0]}, {2'h1, rnd[7:0]});
            host.access(a, 16'h0000, 5'h00, S_RD, 1'b1);
            check("raddr", last_ra, a);
        end
        n = wr_cnt + rd_cnt;
        host.access(a, rnd, 5'h00, S_WR, 1'b0);
        host.access(a, rnd, 5'h00, S_RD, 1'b0);
        check("ignored", wr_cnt + rd_cnt, n);
        @(posedge ref_clk); #1 win_ptr_load = 3'h7;
        win_ptr_load_val = $urandom;
        p0 = win_ptr_load_val;
        @(posedge ref_clk); #1 win_ptr_load = 3'h0;
        for (i = 0; i < 3; i = i + 1) begin
            host.access(15'h7E80 + 2 * i, $urandom, 5'h00, S_WR, 1'b1);
            check("wptr", ptr_of(i), p0 + 15'h1);
            check("wbe", last_be, 2'h1);
        end
        host.access(15'h7E80, 16'h0000, 5'h00, S_RD, 1'b1);
        check("rptr", gp_win_ptr, p0 + 15'h2);
        for (i = 1; i < 3; i = i + 1) begin
            host.access(15'h7E05 + 15'h80 * i + 15'h80, 16'h00F0 >> (2 * i), 5'h00, S_WR, 1'b1);
            check("alias", {last_cmd, last_wa}, {i[1:0], 15'h7E05});
        end
        host.access(15'h7E05, 16'h0000, 5'h00, S_RD, 1'b1);
        do_reset(3'h1, 1'b0);
        a = $urandom_range(0, 16127);
        for (i = 1; i < 4; i = i + 1) begin
            rnd = $urandom;
            host.access(a, rnd, 5'h00, (i[0] ? S_LL : 5'h00) | (i[1] ? S_HL : 5'h00), 1'b1);
            check("lanes", {last_be, last_wa}, {i[1:0], a[13:0], 1'b0});
            check("wword", last_wd & {{8{i[1]}}, {8{i[0]}}}, rnd & {{8{i[1]}}, {8{i[0]}}});
        end
        host.access(a, 16'h0000, 5'h00, S_RD, 1'b1);
        check("rword", last_ra, {a[13:0], 1'b0});
        do_reset(3'h2, 1'b0);
        a = $urandom_range(0, 32255);
        host.access($urandom, {1'b0, a}, 5'h00, S_AL, 1'b1);
        for (i = 0; i < 2; i = i + 1) begin
            host.access($urandom, 16'h0000, 5'h00, S_RD, 1'b1);
            check("latched", last_ra, a);
        end
        host.access($urandom, 16'h00C3, 5'h00, S_WR, 1'b1);
        check("latched", last_wa, a);
        do_reset(3'h4, 1'b0);
        // New address, so stale results of the last mode cannot pass
        a = a ^ 15'h0100;
        host.access(a, 16'h003C, 5'h00, S_WR, 1'b1);
        check("enwrite", {last_wa, last_wd[7:0]}, {a, 8'h3C});
        host.access(a, 16'h0000, S_RD, S_WR, 1'b1);
        check("enread", last_ra, a);
        for (i = 0; i < 8; i = i + 1) begin
            do_reset(i[2:0], 1'b0);
            check("mode", port_mode, MTAB[4*i +: 4]);
        end
        do_reset(3'h0, 1'b1);
        n = wr_cnt;
        host.access(a, 16'h0011, 5'h00, S_WR, 1'b1);
        check("disabled", {pd_en, psp_en, ser_en, wr_cnt[3:0]}, {3'h1, n[3:0]});
        complete_run;
    end
endmodule
